// ==== common/swd_consts.svh ====
`ifndef SWD_CONSTS_SVH
`define SWD_CONSTS_SVH
`define SWD_OFS_PRESCALE 16'h0400
`define SWD_OFS_APP_TMO 16'h0410
`define SWD_OFS_BUS_TMO 16'h0420
`define SWD_RST_PRESCALE 16'h09c2
`define SWD_RST_APP_TMO 16'h03e8
`define SWD_RST_BUS_TMO 16'h03e8
`define SWD_PRESCALE_ADD 16'h0002
`define SWD_BASE_NS 40
`define SWD_CLK_NS 8
`define SWD_BASE_CYC (`SWD_BASE_NS / `SWD_CLK_NS)
`endif

// ==== common/swd_pkg.sv ====
package swd_pkg;
	typedef enum logic [4:0] {
		SWD_INIT = 5'h01,
		SWD_PREOP = 5'h02,
		SWD_SAFEOP = 5'h04,
		SWD_OP = 5'h08,
		SWD_BOOT = 5'h10
	} swd_state_t;
	typedef enum logic [2:0] {
		SWD_REQ_INIT = 3'h0,
		SWD_REQ_PREOP = 3'h1,
		SWD_REQ_SAFEOP = 3'h2,
		SWD_REQ_OP = 3'h3,
		SWD_REQ_BOOT = 3'h4
	} swd_req_t;
endpackage : swd_pkg

// ==== verilog/swd_tick_gen.sv ====
`timescale 1ns/10ps
`include "swd_consts.svh"
module swd_tick_gen #(
	parameter int W = 16
) (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic [W-1:0] mult_in,
	output logic tick_out
);
	typedef struct packed {
		logic [2:0] base_cnt;
		logic [W:0] div_cnt;
		logic tick;
	} swd_tick_st_t;
	swd_tick_st_t st_reg;
	swd_tick_st_t st_next;
	logic [W:0] div_end;
	always_comb begin
		st_next = st_reg;
		div_end = {1'b0, mult_in} + {1'b0, `SWD_PRESCALE_ADD} - {{W{1'b0}}, 1'b1};
		st_next.tick = 1'b0;
		if (st_reg.base_cnt == 3'(`SWD_BASE_CYC - 1)) begin
			st_next.base_cnt = 3'h0;
			if (st_reg.div_cnt >= div_end) begin
				st_next.div_cnt = '0;
				st_next.tick = 1'b1;
			end else begin
				st_next.div_cnt = st_reg.div_cnt + 1'b1;
			end
		end else begin
			st_next.base_cnt = st_reg.base_cnt + 3'h1;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign tick_out = st_reg.tick;
	tick_single_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		tick_out |=> !tick_out) else $error("tick lasted two cycles");
	tick_space_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		tick_out |=> !tick_out [*8]) else $error("ticks too close");
	tick_seen_c: cover property (@(posedge core_clk_in) tick_out);
endmodule : swd_tick_gen

// ==== verilog/swd_core.sv ====
`timescale 1ns/10ps
`include "swd_consts.svh"
module swd_core #(
	parameter int W = 16,
	parameter int DW = 8
) (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic [2:0] state_req_in,
	input wire logic state_req_valid_in,
	input wire logic mbx_cfg_ok_in,
	input wire logic pd_cfg_ok_in,
	input wire logic bus_pd_access_in,
	input wire logic app_pd_exchange_in,
	input wire logic [DW-1:0] master_out_data_in,
	input wire logic [DW-1:0] inputs_in,
	output logic [15:0] reg_rdata_out,
	output logic [4:0] state_out,
	output logic state_err_out,
	output logic mbx_enable_out,
	output logic foe_only_out,
	output logic pd_enable_out,
	output logic [DW-1:0] phys_out,
	output logic [DW-1:0] dual_port_buffer_out,
	output logic bus_wd_expired_out,
	output logic app_wd_expired_out
);
	typedef struct packed {
		logic [W-1:0] prescale;
		logic [W-1:0] app_tmo;
		logic [W-1:0] bus_tmo;
		logic [W-1:0] bus_cnt;
		logic [W-1:0] app_cnt;
		logic bus_exp;
		logic app_exp;
		swd_pkg::swd_state_t state;
		logic err;
		logic [15:0] rdata;
		logic [DW-1:0] phys;
		logic [DW-1:0] dpb;
		logic [2:0] sync_req;
		logic [1:0] sync_bus;
		logic [1:0] sync_app;
		logic mbx_en;
		logic foe_only;
		logic pd_en;
	} swd_st_t;
	swd_st_t st_reg;
	swd_st_t st_next;
	logic tick;
	logic req_pulse;
	logic bus_ev;
	logic app_ev;
	logic bus_wd_on;
	swd_tick_gen #(.W(W)) u_tick (
		.core_clk_in(core_clk_in),
		.resetn_in(resetn_in),
		.mult_in(st_reg.prescale),
		.tick_out(tick)
	);
	// Request strobe is assumed on-clock; bus events come from pins, so synchronise
	assign req_pulse = state_req_valid_in;
	assign bus_ev = st_reg.sync_bus[1];
	assign app_ev = st_reg.sync_app[1];
	assign bus_wd_on = (st_reg.bus_tmo != '0);
	always_comb begin
		st_next = st_reg;
		st_next.sync_bus = {st_reg.sync_bus[0], bus_pd_access_in};
		st_next.sync_app = {st_reg.sync_app[0], app_pd_exchange_in};
		// Register writes; config is honoured in any state
		if (reg_wr_in) begin
			if (reg_addr_in == `SWD_OFS_PRESCALE) begin
				st_next.prescale = reg_wdata_in[W-1:0];
			end else if (reg_addr_in == `SWD_OFS_APP_TMO) begin
				st_next.app_tmo = reg_wdata_in[W-1:0];
			end else if (reg_addr_in == `SWD_OFS_BUS_TMO) begin
				st_next.bus_tmo = reg_wdata_in[W-1:0];
			end
		end
		if (reg_rd_in) begin
			if (reg_addr_in == `SWD_OFS_PRESCALE) begin
				st_next.rdata = 16'(st_reg.prescale);
			end else if (reg_addr_in == `SWD_OFS_APP_TMO) begin
				st_next.rdata = 16'(st_reg.app_tmo);
			end else if (reg_addr_in == `SWD_OFS_BUS_TMO) begin
				st_next.rdata = 16'(st_reg.bus_tmo);
			end else begin
				st_next.rdata = 16'h0000;
			end
		end
		// Bus-side watchdog: restart wins over expiry in the same cycle
		if (bus_ev) begin
			st_next.bus_cnt = '0;
			st_next.bus_exp = 1'b0;
		end else if (!bus_wd_on) begin
			st_next.bus_cnt = '0;
			st_next.bus_exp = 1'b0;
		end else if (tick && !st_reg.bus_exp) begin
			if (st_reg.bus_cnt + 1'b1 >= st_reg.bus_tmo) begin
				st_next.bus_exp = 1'b1;
			end
			st_next.bus_cnt = st_reg.bus_cnt + 1'b1;
		end
		// App watchdog: zero count disables it too
		if (app_ev || st_reg.app_tmo == '0) begin
			st_next.app_cnt = '0;
			st_next.app_exp = 1'b0;
		end else if (tick && !st_reg.app_exp) begin
			if (st_reg.app_cnt + 1'b1 >= st_reg.app_tmo) begin
				st_next.app_exp = 1'b1;
			end
			st_next.app_cnt = st_reg.app_cnt + 1'b1;
		end
		// State machine
		if (req_pulse) begin
			st_next.err = 1'b0;
			case (st_reg.state)
				swd_pkg::SWD_INIT: begin
					if (state_req_in == swd_pkg::SWD_REQ_PREOP) begin
						if (mbx_cfg_ok_in) begin
							st_next.state = swd_pkg::SWD_PREOP;
						end else begin
							st_next.err = 1'b1;
						end
					end else if (state_req_in == swd_pkg::SWD_REQ_BOOT) begin
						st_next.state = swd_pkg::SWD_BOOT;
					end else if (state_req_in != swd_pkg::SWD_REQ_INIT) begin
						st_next.err = 1'b1;
					end
				end
				swd_pkg::SWD_PREOP: begin
					if (state_req_in == swd_pkg::SWD_REQ_SAFEOP) begin
						if (pd_cfg_ok_in) begin
							st_next.dpb = inputs_in;
							st_next.state = swd_pkg::SWD_SAFEOP;
						end else begin
							st_next.err = 1'b1;
						end
					end else if (state_req_in == swd_pkg::SWD_REQ_INIT) begin
						st_next.state = swd_pkg::SWD_INIT;
					end else if (state_req_in != swd_pkg::SWD_REQ_PREOP) begin
						st_next.err = 1'b1;
					end
				end
				swd_pkg::SWD_SAFEOP: begin
					if (state_req_in == swd_pkg::SWD_REQ_OP) begin
						st_next.state = swd_pkg::SWD_OP;
					end else if (state_req_in == swd_pkg::SWD_REQ_PREOP) begin
						st_next.state = swd_pkg::SWD_PREOP;
					end else if (state_req_in == swd_pkg::SWD_REQ_INIT) begin
						st_next.state = swd_pkg::SWD_INIT;
					end else if (state_req_in != swd_pkg::SWD_REQ_SAFEOP) begin
						st_next.err = 1'b1;
					end
				end
				swd_pkg::SWD_OP: begin
					if (state_req_in == swd_pkg::SWD_REQ_SAFEOP) begin
						st_next.state = swd_pkg::SWD_SAFEOP;
					end else if (state_req_in == swd_pkg::SWD_REQ_PREOP) begin
						st_next.state = swd_pkg::SWD_PREOP;
					end else if (state_req_in == swd_pkg::SWD_REQ_INIT) begin
						st_next.state = swd_pkg::SWD_INIT;
					end else if (state_req_in != swd_pkg::SWD_REQ_OP) begin
						st_next.err = 1'b1;
					end
				end
				swd_pkg::SWD_BOOT: begin
					if (state_req_in == swd_pkg::SWD_REQ_INIT) begin
						st_next.state = swd_pkg::SWD_INIT;
					end else if (state_req_in != swd_pkg::SWD_REQ_BOOT) begin
						st_next.err = 1'b1;
					end
				end
				default: begin
					st_next.state = swd_pkg::SWD_INIT;
				end
			endcase
		end
		// Inputs refresh cyclically once process data runs
		if ((st_reg.state == swd_pkg::SWD_SAFEOP) || (st_reg.state == swd_pkg::SWD_OP)) begin
			if (!(req_pulse && st_reg.state == swd_pkg::SWD_PREOP)) begin
				st_next.dpb = inputs_in;
			end
		end
		// Outputs: driven in Op until the watchdog expires, or in Safe-Op only with the watchdog off
		if (bus_wd_on && st_next.bus_exp) begin
			st_next.phys = '0;
		end else if (st_reg.state == swd_pkg::SWD_OP) begin
			st_next.phys = master_out_data_in;
		end else if (st_reg.state == swd_pkg::SWD_SAFEOP && !bus_wd_on) begin
			st_next.phys = master_out_data_in;
		end else begin
			st_next.phys = '0;
		end
		// Service gating registered so the pins carry no decode glitches
		st_next.mbx_en = 1'b0;
		st_next.foe_only = 1'b0;
		st_next.pd_en = 1'b0;
		case (st_next.state)
			swd_pkg::SWD_PREOP: begin
				st_next.mbx_en = 1'b1;
			end
			swd_pkg::SWD_SAFEOP: begin
				st_next.mbx_en = 1'b1;
				st_next.pd_en = 1'b1;
			end
			swd_pkg::SWD_OP: begin
				st_next.mbx_en = 1'b1;
				st_next.pd_en = 1'b1;
			end
			swd_pkg::SWD_BOOT: begin
				st_next.foe_only = 1'b1;
			end
			default: begin
				st_next.mbx_en = 1'b0;
			end
		endcase
	end
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			st_reg <= '0;
			st_reg.prescale <= `SWD_RST_PRESCALE;
			st_reg.app_tmo <= `SWD_RST_APP_TMO;
			st_reg.bus_tmo <= `SWD_RST_BUS_TMO;
			st_reg.state <= swd_pkg::SWD_INIT;
		end else begin
			st_reg <= st_next;
		end
	end
	assign reg_rdata_out = st_reg.rdata;
	assign state_out = st_reg.state;
	assign state_err_out = st_reg.err;
	assign mbx_enable_out = st_reg.mbx_en;
	assign foe_only_out = st_reg.foe_only;
	assign pd_enable_out = st_reg.pd_en;
	assign phys_out = st_reg.phys;
	assign dual_port_buffer_out = st_reg.dpb;
	assign bus_wd_expired_out = st_reg.bus_exp;
	assign app_wd_expired_out = st_reg.app_exp;
	boot_entry_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		(state_out == swd_pkg::SWD_BOOT && $past(state_out) != swd_pkg::SWD_BOOT)
		|-> $past(state_out) == swd_pkg::SWD_INIT) else $error("boot not from init");
	expire_clear_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		bus_wd_expired_out |-> phys_out == '0) else $error("outputs live after expiry");
	wd_off_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		(st_reg.bus_tmo == '0) |=> !bus_wd_expired_out) else $error("disabled wd fired");
	restart_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		bus_ev |=> (st_reg.bus_cnt == '0 && !bus_wd_expired_out)) else $error("no restart");
	app_restart_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		app_ev |=> !app_wd_expired_out) else $error("app wd not restarted");
	safe_hold_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		(state_out == swd_pkg::SWD_SAFEOP && st_reg.bus_tmo != '0) [*2] |-> phys_out == '0)
		else $error("safeop outputs not safe");
	preop_gate_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		(state_out != swd_pkg::SWD_SAFEOP && state_out != swd_pkg::SWD_OP) [*2]
		|-> phys_out == '0) else $error("outputs live outside op");
	init_mbx_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		(state_out == swd_pkg::SWD_PREOP && $past(state_out) == swd_pkg::SWD_INIT)
		|-> $past(mbx_cfg_ok_in)) else $error("preop without mailbox check");
	init_quiet_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		state_out == swd_pkg::SWD_INIT |-> !mbx_enable_out && !pd_enable_out && !foe_only_out)
		else $error("service open in init");
	boot_gate_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		state_out == swd_pkg::SWD_BOOT |-> foe_only_out && !mbx_enable_out && !pd_enable_out)
		else $error("boot gating wrong");
	preop_mbx_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		state_out == swd_pkg::SWD_PREOP |-> mbx_enable_out && !pd_enable_out)
		else $error("preop gating wrong");
	pd_run_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		(state_out == swd_pkg::SWD_SAFEOP || state_out == swd_pkg::SWD_OP)
		|-> mbx_enable_out && pd_enable_out) else $error("process data not open");
	op_copy_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
		(state_out == swd_pkg::SWD_OP && !st_next.bus_exp)
		|=> phys_out == $past(master_out_data_in)) else $error("op outputs not copied");
	op_c: cover property (@(posedge core_clk_in) state_out == swd_pkg::SWD_OP);
	safeop_c: cover property (@(posedge core_clk_in) state_out == swd_pkg::SWD_SAFEOP);
	boot_c: cover property (@(posedge core_clk_in) state_out == swd_pkg::SWD_BOOT);
	exp_c: cover property (@(posedge core_clk_in) bus_wd_expired_out);
endmodule : swd_core

// ==== verif/swd_master_model.sv ====
`timescale 1ns/10ps
module swd_master_model #(
	parameter logic [7:0] OUT_VALUE = 8'h5a
) (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic run_in,
	output logic pd_access_out,
	output logic [7:0] out_data_out
);
	logic [2:0] phase_reg;
	// Output image is loaded before any state request, so it is valid ahead of Op
	initial begin
		phase_reg = 3'h0;
		pd_access_out = 1'b0;
		out_data_out = OUT_VALUE;
	end
	// Short access burst every eight cycles; silent when traffic is stopped
	always @(negedge core_clk_in) begin
		if (!resetn_in || !run_in) begin
			phase_reg <= 3'h0;
			pd_access_out <= 1'b0;
		end else begin
			phase_reg <= phase_reg + 3'h1;
			pd_access_out <= (phase_reg < 3'h2);
		end
	end
endmodule : swd_master_model

// ==== verif/slave_watchdog_and_state_machine_bench.sv ====
`timescale 1ns/10ps
`include "swd_consts.svh"
module slave_watchdog_and_state_machine_bench;
	logic core_clk_in, resetn_in, reg_wr_in, reg_rd_in, state_req_valid_in, run;
	logic mbx_cfg_ok_in, pd_cfg_ok_in, bus_pd_access_in, app_pd_exchange_in;
	logic [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic [2:0] state_req_in;
	logic [7:0] master_out_data_in, inputs_in, phys_out, dual_port_buffer_out;
	logic [4:0] state_out;
	logic state_err_out, bus_wd_expired_out, app_wd_expired_out;
	logic mbx_enable_out, foe_only_out, pd_enable_out;
	int bad_count = 0;
	int compares = 0;
	int n;

	swd_core i_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.state_req_in(state_req_in), .state_req_valid_in(state_req_valid_in),
		.mbx_cfg_ok_in(mbx_cfg_ok_in), .pd_cfg_ok_in(pd_cfg_ok_in),
		.bus_pd_access_in(bus_pd_access_in), .app_pd_exchange_in(app_pd_exchange_in),
		.master_out_data_in(master_out_data_in), .inputs_in(inputs_in),
		.reg_rdata_out(reg_rdata_out), .state_out(state_out), .state_err_out(state_err_out),
		.mbx_enable_out(mbx_enable_out), .foe_only_out(foe_only_out),
		.pd_enable_out(pd_enable_out), .phys_out(phys_out),
		.dual_port_buffer_out(dual_port_buffer_out), .bus_wd_expired_out(bus_wd_expired_out),
		.app_wd_expired_out(app_wd_expired_out));

	swd_master_model i_master (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .run_in(run),
		.pd_access_out(bus_pd_access_in), .out_data_out(master_out_data_in));

	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end

	task automatic report_and_stop;
		if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic reg_wr(input logic [15:0] addr, input logic [15:0] data);
		reg_addr_in = addr;
		reg_wdata_in = data;
		reg_wr_in = 1'b1;
		@(negedge core_clk_in);
		reg_wr_in = 1'b0;
		@(negedge core_clk_in);
	endtask : reg_wr

	task automatic reg_rd(input logic [15:0] addr, input logic [15:0] exp);
		reg_addr_in = addr;
		reg_rd_in = 1'b1;
		@(negedge core_clk_in);
		reg_rd_in = 1'b0;
		chk(reg_rdata_out, exp);
		@(negedge core_clk_in);
	endtask : reg_rd

	// Request taken at one edge, state and error flag settle by the next falling edge
	task automatic req(input logic [2:0] code, input logic [4:0] st, input logic err);
		state_req_in = code;
		state_req_valid_in = 1'b1;
		@(negedge core_clk_in);
		state_req_valid_in = 1'b0;
		chk(16'(state_out), 16'(st));
		chk(16'(state_err_out), 16'(err));
		@(negedge core_clk_in);
	endtask : req

	// Tick is 15 cycles with multiplier 1; two ticks plus sync slack
	task automatic wait_exp(input bit app);
		n = 0;
		while (((app ? app_wd_expired_out : bus_wd_expired_out) !== 1'b1) && n < 200) begin
			@(negedge core_clk_in);
			n++;
		end
		chk(16'(n >= 15 && n <= 60), 16'h0001);
	endtask : wait_exp

	initial begin
		repeat (20000) @(posedge core_clk_in);
		bad_count++;
		report_and_stop();
	end

	initial begin
		{resetn_in, reg_wr_in, reg_rd_in, state_req_valid_in, run} = 5'h00;
		{mbx_cfg_ok_in, pd_cfg_ok_in, app_pd_exchange_in} = 3'h0;
		reg_addr_in = 16'h0000;
		reg_wdata_in = 16'h0000;
		state_req_in = 3'h0;
		inputs_in = 8'h3c;
		repeat (12) @(negedge core_clk_in);
		resetn_in = 1'b1;
		app_pd_exchange_in = 1'b1;
		chk(16'(state_out), 16'(swd_pkg::SWD_INIT));
		chk(16'(phys_out), 16'h0000);
		chk(16'({mbx_enable_out, foe_only_out, pd_enable_out}), 16'h0000);
		reg_rd(`SWD_OFS_PRESCALE, `SWD_RST_PRESCALE);
		reg_rd(`SWD_OFS_APP_TMO, `SWD_RST_APP_TMO);
		reg_rd(`SWD_OFS_BUS_TMO, `SWD_RST_BUS_TMO);
		reg_rd(16'h0404, 16'h0000);
		reg_wr(`SWD_OFS_PRESCALE, 16'h0001);
		reg_rd(`SWD_OFS_PRESCALE, 16'h0001);
		reg_wr(`SWD_OFS_APP_TMO, 16'hffff);
		reg_rd(`SWD_OFS_APP_TMO, 16'hffff);
		req(swd_pkg::SWD_REQ_BOOT, swd_pkg::SWD_BOOT, 1'b0);
		chk(16'({mbx_enable_out, foe_only_out, pd_enable_out}), 16'h0002);
		req(swd_pkg::SWD_REQ_INIT, swd_pkg::SWD_INIT, 1'b0);
		req(swd_pkg::SWD_REQ_SAFEOP, swd_pkg::SWD_INIT, 1'b1);
		req(swd_pkg::SWD_REQ_PREOP, swd_pkg::SWD_INIT, 1'b1);
		mbx_cfg_ok_in = 1'b1;
		req(swd_pkg::SWD_REQ_PREOP, swd_pkg::SWD_PREOP, 1'b0);
		chk(16'({mbx_enable_out, foe_only_out, pd_enable_out}), 16'h0004);
		req(swd_pkg::SWD_REQ_BOOT, swd_pkg::SWD_PREOP, 1'b1);
		req(swd_pkg::SWD_REQ_SAFEOP, swd_pkg::SWD_PREOP, 1'b1);
		pd_cfg_ok_in = 1'b1;
		run = 1'b1;
		req(swd_pkg::SWD_REQ_SAFEOP, swd_pkg::SWD_SAFEOP, 1'b0);
		chk(16'(dual_port_buffer_out), 16'h003c);
		chk(16'({mbx_enable_out, foe_only_out, pd_enable_out}), 16'h0005);
		inputs_in = 8'hc3;
		repeat (20) @(negedge core_clk_in);
		chk(16'(dual_port_buffer_out), 16'h00c3);
		chk(16'(phys_out), 16'h0000);
		req(swd_pkg::SWD_REQ_OP, swd_pkg::SWD_OP, 1'b0);
		chk(16'({mbx_enable_out, foe_only_out, pd_enable_out}), 16'h0005);
		repeat (5) @(negedge core_clk_in);
		chk(16'(phys_out), 16'h005a);
		// Zero timeout: outputs keep following the master with traffic gone
		reg_wr(`SWD_OFS_BUS_TMO, 16'h0000);
		run = 1'b0;
		repeat (100) @(negedge core_clk_in);
		chk(16'(bus_wd_expired_out), 16'h0000);
		chk(16'(phys_out), 16'h005a);
		run = 1'b1;
		reg_wr(`SWD_OFS_BUS_TMO, 16'h0002);
		repeat (100) @(negedge core_clk_in);
		chk(16'(bus_wd_expired_out), 16'h0000);
		// Stop traffic just after an access so the expiry window is known
		while (bus_pd_access_in !== 1'b1) @(negedge core_clk_in);
		run = 1'b0;
		wait_exp(1'b0);
		@(negedge core_clk_in);
		chk(16'(phys_out), 16'h0000);
		chk(16'(state_out), 16'(swd_pkg::SWD_OP));
		reg_wr(`SWD_OFS_APP_TMO, 16'h0002);
		repeat (100) @(negedge core_clk_in);
		chk(16'(app_wd_expired_out), 16'h0000);
		app_pd_exchange_in = 1'b0;
		wait_exp(1'b1);
		report_and_stop();
	end
endmodule : slave_watchdog_and_state_machine_bench
